//--- src/lcdcd_pkg.sv
// Package of constants for the LCD command decoder
package lcdcd_pkg;
   localparam int unsigned NUM_COLS = 132;
   localparam logic [7:0] COL_LAST = 8'h83;
   localparam logic [7:0] COL_FIRST = 8'h00;
   localparam logic [3:0] PAGE_LAST = 4'h8;
   localparam logic [3:0] PAGE_RST = 4'h0;
   localparam int unsigned BUF_DEPTH = 2;
   localparam logic [7:0] CMD_SEG_DIR = 8'hA0;
   localparam logic [7:0] CMD_SEG_MASK = 8'hFE;
   localparam logic [7:0] CMD_BIAS = 8'hA2;
   localparam logic [7:0] CMD_BIAS_MASK = 8'hFE;
   localparam logic [7:0] CMD_COM_DIR = 8'hC0;
   localparam logic [7:0] CMD_COM_MASK = 8'hF0;
   localparam logic [7:0] CMD_DISP_ONOFF = 8'hAE;
   localparam logic [7:0] CMD_REVERSE = 8'hA6;
   localparam logic [7:0] CMD_ALLON = 8'hA4;
   localparam logic [7:0] CMD_ONE_MASK = 8'hFE;
   localparam logic [7:0] CMD_PAGE = 8'hB0;
   localparam logic [7:0] CMD_NIB_MASK = 8'hF0;
   localparam logic [7:0] CMD_COL_HI = 8'h10;
   localparam logic [7:0] CMD_COL_LO = 8'h00;
   localparam logic [7:0] CMD_START = 8'h40;
   localparam logic [7:0] CMD_START_MASK = 8'hC0;
   localparam logic [7:0] CMD_RMW = 8'hE0;
   localparam logic [7:0] CMD_END = 8'hEE;
   localparam logic [7:0] CMD_RESET = 8'hE2;
   localparam logic [7:0] CMD_NOP = 8'hE3;
   localparam logic [7:0] CMD_POWER = 8'h28;
   localparam logic [7:0] CMD_RATIO = 8'h20;
   localparam logic [7:0] CMD_PWR_MASK = 8'hF8;
   localparam logic [7:0] CMD_VOLUME = 8'h80;
   localparam logic [7:0] CMD_VOL_MASK = 8'hE0;
   localparam logic [7:0] CMD_TEST = 8'hD0;
   localparam logic [7:0] CMD_TEST_MASK = 8'hD0;
   localparam logic [2:0] RATIO_RST = 3'h0;
   localparam logic [4:0] VOLUME_RST = 5'h00;
   localparam logic BIAS_RST = 1'b1;
   localparam logic [2:0] POWER_RST = 3'h0;
endpackage : lcdcd_pkg

//--- src/lcdcd_top.sv
// Command decoder of a dot-matrix LCD driver with display RAM
// Overview of operation
// R1: Byte with cmd_data_select low is a command; 8080 low / 6800 high strobe.
// R2: 1010000x selects segment direction, D0 set reverses it.
// R3: 1100xxxx selects common direction from D3, low bits ignored.
// R4: Data read returns byte at page/column, then column advances by one.
// R5: First read after address setting returns no valid data.
// R6: Data write stores byte at page/column, then column advances by one.
// R7: Column advance wraps from the last column to zero.
// R8: 11100000 enters read-modify-write, records column; reads hold column.
// R9: End leaves read-modify-write and restores recorded column.
// R10: End is command byte 11101110.
// R11: Only the column is restored; the page stays as it is.
// R12: Host must not set the column during read-modify-write.
// R13: 00101xyz sets booster, regulator and follower enables.
// R14: 00100xxx loads 3-bit resistor ratio; 111 is external mode.
// R15: 100xxxxx loads the 5-bit electronic volume.
// R16: 1010001x selects bias: 0 gives 1/9, 1 gives 1/7.
// R17: Bias takes effect only while the follower is enabled.
// R18: All-points-on while display off enters power saver.
// R19: Power saver stops oscillator, power, drivers; outputs grounded. Code leaves booster_en, regulator_en and follower_en as set.
// R20: Power saver keeps data and modes, host access still works.
// R21: 11100010 resets settings and shorts regulated voltage to ground.
// R22: Software reset never shorts booster output; only the pin does.
// R23: 11100011 is a no-operation.
// R24: Unclaimed 11x1xxxx enters test mode; reset or display on/off clears.
// R25: Host should rewrite operating modes periodically against noise.
// R26: Serial bytes are shifted in most significant bit first.
`timescale 1ns/100ps
module lcdcd_top (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic mode_6800,
   input wire logic serial_sel,
   input wire logic cmd_data_select,
   input wire logic chip_sel_n,
   input wire logic rd_e,
   input wire logic wr_rw,
   input wire logic [7:0] data_in,
   input wire logic ser_clk,
   input wire logic ser_data,
   output logic [7:0] data_out,
   output logic data_oe_n,
   output logic ram_we,
   output logic [3:0] ram_page,
   output logic [7:0] ram_col,
   output logic [7:0] ram_wdata,
   input wire logic [7:0] ram_rdata,
   output logic rd_valid,
   input wire logic rd_ready,
   output logic seg_reverse,
   output logic com_reverse,
   output logic display_on,
   output logic display_reverse,
   output logic all_points_on,
   output logic [5:0] start_line,
   output logic booster_en,
   output logic regulator_en,
   output logic follower_en,
   output logic [2:0] regulator_resistor_ratio,
   output logic [4:0] volume,
   output logic bias_eff,
   output logic power_saver,
   output logic osc_stop,
   output logic drivers_grounded,
   output logic regulated_lcd_voltage_short,
   output logic booster_output_short,
   output logic test_mode,
   output logic rmw_active
);
   // Two-flop synchronisers for all pins
   logic [7:0] s1_r, s2_r;
   logic [5:0] c1_r, c2_r;
   logic [5:0] cp_r;
   // Interface selects are pins too; nothing taps the first flop
   logic [1:0] m1_r, m2_r;
   logic sel_6800, sel_ser;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         s1_r <= 8'h00;
         s2_r <= 8'h00;
         c1_r <= 6'h00;
         c2_r <= 6'h00;
         cp_r <= 6'h00;
         m1_r <= 2'h0;
         m2_r <= 2'h0;
      end else begin
         s1_r <= data_in;
         s2_r <= s1_r;
         c1_r <= {ser_data, ser_clk, cmd_data_select, chip_sel_n, rd_e,
                  wr_rw};
         c2_r <= c1_r;
         cp_r <= c2_r;
         m1_r <= {mode_6800, serial_sel};
         m2_r <= m1_r;
      end
   end
   logic sd, sck, sck_p, a0, csn, rde, wrw, rde_p, wrw_p;
   assign {sd, sck, a0, csn, rde, wrw} = c2_r;
   assign sck_p = cp_r[4];
   assign rde_p = cp_r[1];
   assign wrw_p = cp_r[0];
   assign {sel_6800, sel_ser} = m2_r;
   // Strobe edges; data and A0 sampled at strobe end, so setup is met
   logic par_wr, par_rd;
   always_comb begin
      if (sel_6800) begin
         par_wr = !csn && !rde && rde_p && !wrw; // [R1]
         par_rd = !csn && !rde && rde_p && wrw;
      end else begin
         par_wr = !csn && wrw && !wrw_p; // [R1]
         par_rd = !csn && rde && !rde_p;
      end
   end
   // Serial shift register, MSB first
   logic [7:0] sh_r;
   logic [2:0] bit_r;
   logic ser_done_r;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         sh_r <= 8'h00;
         bit_r <= 3'h0;
         ser_done_r <= 1'b0;
      end else begin
         ser_done_r <= 1'b0;
         if (!sel_ser || csn) begin
            bit_r <= 3'h0;
         end else if (sck && !sck_p) begin
            sh_r <= {sh_r[6:0], sd}; // [R26]
            bit_r <= bit_r + 3'h1;
            ser_done_r <= (bit_r == 3'h7);
         end
      end
   end
   logic wr_stb, rd_stb;
   logic [7:0] wbyte;
   assign wr_stb = sel_ser ? ser_done_r : par_wr;
   assign rd_stb = !sel_ser && par_rd;
   assign wbyte = sel_ser ? sh_r : s2_r;
   logic is_cmd, is_dat;
   assign is_cmd = wr_stb && !a0; // [R1]
   assign is_dat = wr_stb && a0;
   function automatic logic hit(input logic [7:0] b, input logic [7:0] v,
                                input logic [7:0] m);
      hit = (b & m) == v;
   endfunction : hit
   logic c_seg, c_bias, c_com, c_onoff, c_rev, c_allon, c_page, c_chi,
         c_clo, c_start, c_rmw, c_end, c_rst, c_nop, c_pwr, c_ratio,
         c_vol, c_test;
   always_comb begin
      c_seg = hit(wbyte, lcdcd_pkg::CMD_SEG_DIR, lcdcd_pkg::CMD_SEG_MASK);
      c_bias = hit(wbyte, lcdcd_pkg::CMD_BIAS, lcdcd_pkg::CMD_BIAS_MASK);
      c_com = hit(wbyte, lcdcd_pkg::CMD_COM_DIR, lcdcd_pkg::CMD_COM_MASK);
      c_onoff = hit(wbyte, lcdcd_pkg::CMD_DISP_ONOFF,
                    lcdcd_pkg::CMD_ONE_MASK);
      c_rev = hit(wbyte, lcdcd_pkg::CMD_REVERSE, lcdcd_pkg::CMD_ONE_MASK);
      c_allon = hit(wbyte, lcdcd_pkg::CMD_ALLON, lcdcd_pkg::CMD_ONE_MASK);
      c_page = hit(wbyte, lcdcd_pkg::CMD_PAGE, lcdcd_pkg::CMD_NIB_MASK);
      c_chi = hit(wbyte, lcdcd_pkg::CMD_COL_HI, lcdcd_pkg::CMD_NIB_MASK);
      c_clo = hit(wbyte, lcdcd_pkg::CMD_COL_LO, lcdcd_pkg::CMD_NIB_MASK);
      c_start = hit(wbyte, lcdcd_pkg::CMD_START,
                    lcdcd_pkg::CMD_START_MASK);
      c_rmw = wbyte == lcdcd_pkg::CMD_RMW; // [R8]
      c_end = wbyte == lcdcd_pkg::CMD_END; // [R10]
      c_rst = wbyte == lcdcd_pkg::CMD_RESET;
      c_nop = wbyte == lcdcd_pkg::CMD_NOP; // [R23]
      c_pwr = hit(wbyte, lcdcd_pkg::CMD_POWER, lcdcd_pkg::CMD_PWR_MASK);
      c_ratio = hit(wbyte, lcdcd_pkg::CMD_RATIO, lcdcd_pkg::CMD_PWR_MASK);
      c_vol = hit(wbyte, lcdcd_pkg::CMD_VOLUME, lcdcd_pkg::CMD_VOL_MASK);
      c_test = hit(wbyte, lcdcd_pkg::CMD_TEST, lcdcd_pkg::CMD_TEST_MASK) &&
               !(c_rmw || c_end || c_rst || c_nop || c_onoff); // [R24]
   end
   logic srst;
   assign srst = is_cmd && c_rst; // [R21]
   // Operating modes
   logic bias_r, fol_r;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         seg_reverse <= 1'b0;
         com_reverse <= 1'b0;
         display_on <= 1'b0;
         display_reverse <= 1'b0;
         all_points_on <= 1'b0;
         start_line <= 6'h00;
         booster_en <= lcdcd_pkg::POWER_RST[2];
         regulator_en <= lcdcd_pkg::POWER_RST[1];
         fol_r <= lcdcd_pkg::POWER_RST[0];
         regulator_resistor_ratio <= lcdcd_pkg::RATIO_RST;
         volume <= lcdcd_pkg::VOLUME_RST;
         bias_r <= lcdcd_pkg::BIAS_RST;
         test_mode <= 1'b0;
      end else if (srst) begin
         seg_reverse <= 1'b0; // [R21]
         com_reverse <= 1'b0;
         display_on <= 1'b0;
         display_reverse <= 1'b0;
         all_points_on <= 1'b0;
         start_line <= 6'h00;
         booster_en <= lcdcd_pkg::POWER_RST[2];
         regulator_en <= lcdcd_pkg::POWER_RST[1];
         fol_r <= lcdcd_pkg::POWER_RST[0];
         regulator_resistor_ratio <= lcdcd_pkg::RATIO_RST;
         volume <= lcdcd_pkg::VOLUME_RST;
         bias_r <= lcdcd_pkg::BIAS_RST;
         test_mode <= 1'b0; // [R24]
      end else if (is_cmd) begin
         if (c_seg) seg_reverse <= wbyte[0]; // [R2]
         if (c_com) com_reverse <= wbyte[3]; // [R3]
         if (c_onoff) begin
            display_on <= wbyte[0];
            test_mode <= 1'b0; // [R24]
         end
         if (c_rev) display_reverse <= wbyte[0];
         if (c_allon) all_points_on <= wbyte[0];
         if (c_start) start_line <= wbyte[5:0];
         if (c_pwr) begin
            booster_en <= wbyte[2]; // [R13]
            regulator_en <= wbyte[1];
            fol_r <= wbyte[0];
         end
         if (c_ratio) regulator_resistor_ratio <= wbyte[2:0]; // [R14]
         if (c_vol) volume <= wbyte[4:0]; // [R15]
         if (c_bias) bias_r <= wbyte[0]; // [R16]
         if (c_test) test_mode <= 1'b1; // [R24]
      end
   end
   // Power saver and supply shorts; modes are held, not cleared
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         follower_en <= 1'b0;
         bias_eff <= lcdcd_pkg::BIAS_RST;
         power_saver <= 1'b0;
         osc_stop <= 1'b0;
         drivers_grounded <= 1'b1;
         regulated_lcd_voltage_short <= 1'b1;
         booster_output_short <= 1'b1; // [R22]
      end else begin
         follower_en <= fol_r;
         if (fol_r) bias_eff <= bias_r; // [R17]
         power_saver <= !display_on && all_points_on; // [R18] [R20]
         osc_stop <= !display_on && all_points_on; // [R19]
         drivers_grounded <= (!display_on && all_points_on) ||
                             !display_on;
         regulated_lcd_voltage_short <= srst || !regulator_en; // [R21]
         booster_output_short <= 1'b0; // [R22]
      end
   end
   // Addressing and read-modify-write
   logic [7:0] col_r, saved_col_r;
   logic [3:0] page_r;
   logic dummy_r;
   logic can_take;
   function automatic logic [7:0] col_inc(input logic [7:0] c);
      col_inc = (c == lcdcd_pkg::COL_LAST) ? lcdcd_pkg::COL_FIRST
                : c + 8'h01; // [R7]
   endfunction : col_inc
   logic do_rd;
   assign do_rd = rd_stb && a0 && can_take;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         col_r <= lcdcd_pkg::COL_FIRST;
         page_r <= lcdcd_pkg::PAGE_RST;
         saved_col_r <= lcdcd_pkg::COL_FIRST;
         rmw_active <= 1'b0;
         dummy_r <= 1'b1;
      end else if (srst) begin
         col_r <= lcdcd_pkg::COL_FIRST;
         page_r <= lcdcd_pkg::PAGE_RST;
         rmw_active <= 1'b0;
         dummy_r <= 1'b1;
      end else if (is_cmd && c_page) begin
         page_r <= (wbyte[3:0] > lcdcd_pkg::PAGE_LAST) ?
                   lcdcd_pkg::PAGE_LAST : wbyte[3:0];
         dummy_r <= 1'b1; // [R5]
      end else if (is_cmd && c_chi) begin
         col_r <= {wbyte[3:0], col_r[3:0]};
         dummy_r <= 1'b1; // [R5]
      end else if (is_cmd && c_clo) begin
         col_r <= {col_r[7:4], wbyte[3:0]};
         dummy_r <= 1'b1;
      end else if (is_cmd && c_rmw) begin
         rmw_active <= 1'b1; // [R8]
         saved_col_r <= col_r;
      end else if (is_cmd && c_end && rmw_active) begin
         rmw_active <= 1'b0; // [R9]
         col_r <= saved_col_r; // [R11]
         dummy_r <= 1'b1;
      end else if (is_dat) begin
         col_r <= col_inc(col_r); // [R6]
         dummy_r <= 1'b1;
      end else if (do_rd) begin
         dummy_r <= 1'b0; // [R5]
         if (!dummy_r && !rmw_active) col_r <= col_inc(col_r); // [R4] [R8]
      end
   end
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ram_we <= 1'b0;
         ram_wdata <= 8'h00;
      end else begin
         ram_we <= is_dat && !srst; // [R6]
         ram_wdata <= wbyte;
      end
   end
   assign ram_page = page_r;
   assign ram_col = col_r;
   // Two-entry read buffer; dummy read pushes nothing
   logic [7:0] buf_r [lcdcd_pkg::BUF_DEPTH];
   logic [1:0] cnt_r;
   logic push, pop;
   assign can_take = cnt_r != 2'd2;
   assign push = do_rd && !dummy_r; // [R4]
   assign pop = rd_valid && rd_ready;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         buf_r[0] <= 8'h00;
         buf_r[1] <= 8'h00;
         cnt_r <= 2'd0;
      end else begin
         if (pop) buf_r[0] <= buf_r[1];
         if (push) buf_r[(pop ? cnt_r - 2'd1 : cnt_r) == 2'd0 ? 0 : 1]
            <= ram_rdata;
         cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
      end
   end
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_valid <= 1'b0;
         data_out <= 8'h00;
         data_oe_n <= 1'b1;
      end else begin
         rd_valid <= (cnt_r + {1'b0, push} - {1'b0, pop}) != 2'd0;
         // A pop from a full buffer must expose the second entry
         if (pop) begin
            data_out <= (cnt_r == 2'd2) ? buf_r[1] : ram_rdata;
         end else begin
            data_out <= (cnt_r == 2'd0) ? ram_rdata : buf_r[0];
         end
         data_oe_n <= !(!csn && a0 && !sel_ser &&
                        (sel_6800 ? (rde && wrw) : !rde));
      end
   end
endmodule : lcdcd_top

//--- sim/lcdcd_host_model.sv
// Host model: parallel bus in both timings and the serial link
`timescale 1ns/100ps
module lcdcd_host_model (
   input wire logic core_clk,
   output logic cmd_data_select,
   output logic chip_sel_n,
   output logic rd_e,
   output logic wr_rw,
   output logic [7:0] data_in,
   output logic ser_clk,
   output logic ser_data
);
   initial begin
      cmd_data_select = 1'b0;
      chip_sel_n = 1'b1;
      rd_e = 1'b1;
      wr_rw = 1'b1;
      data_in = 8'h00;
      ser_clk = 1'b0;
      ser_data = 1'b0;
   end
   // Low pulse on the write strobe, data held past its end
   task automatic put(input logic a0, input logic [7:0] d);
      @(negedge core_clk);
      cmd_data_select = a0;
      data_in = d;
      chip_sel_n = 1'b0;
      wr_rw = 1'b0;
      repeat (3) @(negedge core_clk);
      wr_rw = 1'b1;
      repeat (5) @(negedge core_clk);
      chip_sel_n = 1'b1;
      // Released bus shows no stale byte
      data_in = ~d;
      @(negedge core_clk);
   endtask : put
   // Display data read, select line high
   task automatic get();
      @(negedge core_clk);
      cmd_data_select = 1'b1;
      chip_sel_n = 1'b0;
      rd_e = 1'b0;
      repeat (3) @(negedge core_clk);
      rd_e = 1'b1;
      repeat (5) @(negedge core_clk);
      chip_sel_n = 1'b1;
      @(negedge core_clk);
   endtask : get
   // High pulse on E with R/W low; byte taken as E falls
   task automatic put68(input logic a0, input logic [7:0] d);
      @(negedge core_clk);
      cmd_data_select = a0;
      data_in = d;
      chip_sel_n = 1'b0;
      wr_rw = 1'b0;
      rd_e = 1'b1;
      repeat (3) @(negedge core_clk);
      rd_e = 1'b0;
      repeat (5) @(negedge core_clk);
      chip_sel_n = 1'b1;
      wr_rw = 1'b1;
      data_in = ~d;
      @(negedge core_clk);
   endtask : put68
   // Serial byte, MSB first; clock rests low outside the frame
   task automatic send(input logic a0, input logic [7:0] d);
      @(negedge core_clk);
      cmd_data_select = a0;
      chip_sel_n = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         ser_data = d[i];
         repeat (2) @(negedge core_clk);
         ser_clk = 1'b1;
         repeat (2) @(negedge core_clk);
         ser_clk = 1'b0;
      end
      repeat (5) @(negedge core_clk);
      chip_sel_n = 1'b1;
      ser_data = ~d[0];
      @(negedge core_clk);
   endtask : send
endmodule : lcdcd_host_model

//--- sim/lcdcd_assertions.sv
// Checker of the LCD command decoder
`timescale 1ns/100ps
module lcdcd_checker (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic ram_we,
   input wire logic [7:0] ram_col,
   input wire logic rd_valid,
   input wire logic rd_ready,
   input wire logic [7:0] data_out,
   input wire logic display_on,
   input wire logic all_points_on,
   input wire logic power_saver,
   input wire logic osc_stop,
   input wire logic drivers_grounded,
   input wire logic booster_output_short,
   input wire logic rmw_active
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   logic rmw_d_r;
   logic [7:0] rec_r;
   // Entry column captured on the rising mode flag
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rmw_d_r <= 1'b0;
         rec_r <= 8'h00;
      end else begin
         rmw_d_r <= rmw_active;
         if (rmw_active && !rmw_d_r) begin
            rec_r <= ram_col;
         end
      end
   end
   sequence ps_cond;
      (!display_on && all_points_on) [*2];
   endsequence
   sequence rmw_end;
      $fell(rmw_active);
   endsequence
   saver_entry_a: assert property (ps_cond |-> power_saver)
      else $error("power saver not entered");
   saver_state_a: assert property (
      power_saver |-> osc_stop && drivers_grounded)
      else $error("power saver outputs wrong");
   we_pulse_a: assert property (ram_we |=> !ram_we)
      else $error("write pulse too long");
   col_step_a: assert property (
      ram_we && $past(ram_col) != lcdcd_pkg::COL_LAST
      |-> ram_col == $past(ram_col) + 8'h01)
      else $error("column not advanced");
   col_wrap_a: assert property (
      ram_we && $past(ram_col) == lcdcd_pkg::COL_LAST
      |-> ram_col == lcdcd_pkg::COL_FIRST)
      else $error("column not wrapped");
   read_hold_a: assert property (
      rd_valid && !rd_ready |=> rd_valid && $stable(data_out))
      else $error("read byte lost");
   boost_short_a: assert property (
      !booster_output_short |=> !booster_output_short)
      else $error("booster output shorted");
   rmw_restore_a: assert property (rmw_end |-> ram_col == rec_r)
      else $error("column not restored");
   rmw_hold_a: assert property (
      rmw_active && $past(rmw_active) && !ram_we |-> $stable(ram_col))
      else $error("column moved in rmw");
endmodule : lcdcd_checker
bind lcdcd_top lcdcd_checker chk (.*);

//--- sim/lcdcd_top_test.sv
// Testbench of the LCD command decoder
`timescale 1ns/100ps
module lcdcd_top_test;
   logic core_clk = 1'b0, arst_n = 1'b0, rd_ready = 1'b0;
   // Interface selects, changed only between transfers
   logic mode_6800 = 1'b0, serial_sel = 1'b0;
   logic ser_clk, ser_data;
   logic cmd_data_select, chip_sel_n, rd_e, wr_rw;
   logic [7:0] data_in, data_out, ram_col, ram_wdata, ram_rdata;
   logic [3:0] ram_page;
   logic [5:0] start_line;
   logic [2:0] regulator_resistor_ratio;
   logic [4:0] volume;
   logic data_oe_n, ram_we, rd_valid, seg_reverse, com_reverse;
   logic display_on, display_reverse, all_points_on, booster_en;
   logic regulator_en, follower_en, bias_eff, power_saver, osc_stop;
   logic drivers_grounded, regulated_lcd_voltage_short;
   logic booster_output_short, test_mode, rmw_active;
   int failures = 0, check_count = 0;
   logic [7:0] mem [0:4095];
   logic [11:0] wa;
   lcdcd_top uut (.*);
   lcdcd_host_model host (.*);
   always #25 core_clk = ~core_clk;
   // Write lands at the address held before the advance
   assign ram_rdata = mem[{ram_page, ram_col}];
   always @(posedge core_clk) begin
      wa <= {ram_page, ram_col};
      if (ram_we) mem[wa] <= ram_wdata;
   end
   task automatic chk(string n, logic [7:0] s, logic [7:0] e);
      check_count++;
      if (s !== e) begin
         failures++;
         $display("wrong value %s exp %h got %h", n, e, s);
      end
   endtask : chk
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : summarize
   task automatic drain(logic [7:0] e);
      int i;
      for (i = 0; i < 20 && rd_valid !== 1'b1; i++) @(negedge core_clk);
      if (i == 20) begin
         failures++;
         summarize();
      end
      chk("data_out", data_out, e);
      rd_ready = 1'b1;
      @(negedge core_clk);
      rd_ready = 1'b0;
      @(negedge core_clk);
   endtask : drain
   task automatic t_modes();
      chk("boost_short", booster_output_short, 1'b0);
      host.put(0, 8'hA1);
      chk("seg", seg_reverse, 1'b1);
      host.put(0, 8'hA0);
      chk("seg", seg_reverse, 1'b0);
      host.put(0, 8'hC7);
      chk("com", com_reverse, 1'b0);
      host.put(0, 8'hC8);
      chk("com", com_reverse, 1'b1);
      host.put(0, 8'h2D);
      chk("pwr", {booster_en, regulator_en, follower_en}, 3'h5);
      host.put(0, 8'h27);
      chk("ratio", regulator_resistor_ratio, 3'h7);
      host.put(0, 8'h26);
      chk("ratio", regulator_resistor_ratio, 3'h6);
      host.put(0, 8'h9F);
      chk("volume", volume, 5'h1F);
      host.put(0, 8'hA2);
      chk("bias", bias_eff, 1'b0);
      host.put(0, 8'hA3);
      chk("bias", bias_eff, 1'b1);
      // Segment direction rewritten once more, as a host should
      host.put(0, 8'hA1);
      host.put(0, 8'hE3);
      chk("nop", {seg_reverse, volume}, 6'h3F);
   endtask : t_modes
   task automatic t_rw();
      host.put(0, 8'hB0);
      host.put(0, 8'h18);
      host.put(0, 8'h03);
      host.put(1, 8'h55);
      chk("mem83", mem[12'h083], 8'h55);
      chk("col", ram_col, 8'h00);
      host.put(1, 8'h66);
      chk("mem00", mem[12'h000], 8'h66);
      host.put(0, 8'h10);
      host.put(0, 8'h00);
      // Dummy read first, then the buffer is filled past full
      host.get();
      repeat (3) host.get();
      drain(8'h66);
      drain(mem[12'h001]);
      chk("rd_valid", rd_valid, 1'b0);
   endtask : t_rw
   task automatic t_rmw();
      host.put(0, 8'h10);
      host.put(0, 8'h05);
      host.put(0, 8'hE0);
      chk("rmw", rmw_active, 1'b1);
      host.get();
      host.get();
      drain(mem[12'h005]);
      chk("col", ram_col, 8'h05);
      host.put(1, 8'h77);
      chk("col", ram_col, 8'h06);
      chk("mem05", mem[12'h005], 8'h77);
      // No column set while the mode is open
      host.put(0, 8'hB1);
      host.put(0, 8'hEE);
      chk("rmw", rmw_active, 1'b0);
      chk("col", ram_col, 8'h05);
      chk("page", ram_page, 4'h1);
   endtask : t_rmw
   task automatic t_saver();
      logic [11:0] a;
      host.put(0, 8'hAE);
      host.put(0, 8'hA5);
      chk("saver", power_saver, 1'b1);
      chk("osc", {osc_stop, drivers_grounded}, 2'h3);
      a = {ram_page, ram_col};
      host.put(1, 8'h3C);
      chk("mem", mem[a], 8'h3C);
      chk("volume", volume, 5'h1F);
      host.put(0, 8'hAF);
      chk("saver", power_saver, 1'b0);
      host.put(0, 8'hA4);
   endtask : t_saver
   task automatic t_test();
      host.put(0, 8'hD5);
      chk("test", test_mode, 1'b1);
      host.put(0, 8'hAF);
      chk("test", test_mode, 1'b0);
      host.put(0, 8'hF0);
      chk("test", test_mode, 1'b1);
      host.put(0, 8'hE2);
      chk("test", test_mode, 1'b0);
      chk("volume", volume, 5'h00);
      chk("v_short", regulated_lcd_voltage_short, 1'b1);
      chk("boost_short", booster_output_short, 1'b0);
   endtask : t_test
   // Bit order shows: LSB first would land in test mode instead
   task automatic t_link();
      serial_sel = 1'b1;
      host.send(0, 8'h8B);
      chk("ser_vol", volume, 5'h0B);
      chk("ser_test", test_mode, 1'b0);
      host.send(1, 8'h5A);
      chk("ser_mem", mem[12'h000], 8'h5A);
      serial_sel = 1'b0;
      mode_6800 = 1'b1;
      host.put68(0, 8'hC8);
      chk("com68", com_reverse, 1'b1);
      host.put68(1, 8'h99);
      chk("mem01", mem[12'h001], 8'h99);
   endtask : t_link
   initial begin
      for (int i = 0; i < 4096; i++) mem[i] = i[7:0] ^ 8'hA5;
      repeat (10) @(negedge core_clk);
      arst_n = 1'b1;
      repeat (3) @(negedge core_clk);
      t_modes();
      t_rw();
      t_rmw();
      t_saver();
      t_test();
      t_link();
      summarize();
   end
endmodule : lcdcd_top_test
